/* File: hbp_regs.vh */
`ifndef HBP_REGS_VH
`define HBP_REGS_VH
// byte offsets within the 16-byte window, as word indices (addr[3:2])
`define HBP_W_PTR 2'h1
`define HBP_W_DATA 2'h2
`define HBP_W_MSI 2'h2
`define HBP_W_BANK 2'h3
`define HBP_BANK_OFS 4'hF
`define HBP_BANK_DP 3'h2
`define HBP_BANK_MSI 3'h0
`define HBP_BANK_RST 8'h00
`define HBP_BASE_RST 12'h030
// memory geometry
`define HBP_PAGE_BYTES 2048
`define HBP_MEM_BYTES 8192
`define HBP_MEM_WORDS (`HBP_MEM_BYTES / 4)
`define HBP_RX_BASE 11'h400
// timing: core clock and DMA rate, MHz
`define HBP_CLK_MHZ 250
`define HBP_DMA_MHZ 50
`define HBP_DMA_DIV (`HBP_CLK_MHZ / `HBP_DMA_MHZ)
`define HBP_DMA_LAST 3'h4
// access sequencer states
`define HBP_ST_IDLE 2'h0
`define HBP_ST_WAIT 2'h1
`define HBP_ST_DONE 2'h2
`endif

/* File: hbp_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "hbp_regs.vh"
// Operation
// - decode on upper address lines and address enable against configured base
// - address latch open while strobe low and read/write high, holds after
// - doubleword write at word 0xC updates only the bank selector byte
// - byte lanes pass straight through, no eight-bit mode
// - word halves swap when word half select is high, except on select-driven data path accesses
// - asynchronous accesses timed by read and write strobe edges
// - async ready drops at strobe lead, released later by internal clock
// - sync mode uses bus clock, cycle frame, write-not-read; ready per clock
// - data path select bypasses bank, and decode on asynchronous cycles only; accesses are 32 bits
// - data path select accepted in burst mode or as asynchronous cycle
// - read and write data buffers at data register take any width
// - access the buffers cannot satisfy is held off by not-ready
// - packet RAM reads are full words, lanes chosen by address
// - arbiter shares packet RAM between host and DMA requests
// - DMA packs two 16-bit MAC words into one 32-bit entry
// - DMA runs at 50 MHz rate over a 32-bit memory path
// - separate tx and rx counters, alternated when both request
// - memory size reported in 2048-byte page units, 8 kbytes maximum
module hbp_top #(
    parameter [11:0] BASE = `HBP_BASE_RST,
    parameter AW = 11
) (
    // clock, reset, enable
    input wire i_clk,
    input wire i_rstn,
    input wire i_ce,
    // host bus pins
    input wire i_address_strobe_low,
    input wire i_read_strobe_low,
    input wire i_write_strobe_low,
    input wire i_cycle_frame_low,
    input wire i_local_bus_clock,
    input wire i_write_not_read,
    input wire i_data_path_select_low,
    input wire i_sync_bus_select_low,
    input wire i_address_enable,
    input wire [11:0] i_upper_address_lines,
    input wire [1:0] i_addr_low,
    input wire i_word_half_select,
    input wire [3:0] i_byte_en_low,
    input wire [31:0] i_data,
    output reg [31:0] o_data,
    output reg o_data_oe,
    output reg o_async_cycle_ready,
    output reg o_sync_cycle_ready_low,
    // MAC receive words in
    input wire [15:0] i_rx_word,
    input wire i_rx_valid,
    output reg o_rx_ready,
    // MAC transmit words out
    output reg [15:0] o_tx_word,
    output reg o_tx_valid,
    input wire i_tx_ready
);
    function [31:0] swap_h;
        input [31:0] w;
        input s;
        swap_h = s ? {w[15:0], w[31:16]} : w;
    endfunction

    // pin synchronisers: stage one feeds stage two only
    reg [59:0] s1_r, s2_r, s3_r;
    wire [59:0] pins = {i_data, i_byte_en_low, i_word_half_select, i_addr_low,
        i_upper_address_lines, i_address_enable, i_sync_bus_select_low,
        i_data_path_select_low, i_write_not_read, i_local_bus_clock,
        i_cycle_frame_low, i_write_strobe_low, i_read_strobe_low,
        i_address_strobe_low};
    wire ads_l = s2_r[0];
    wire rd_l = s2_r[1];
    wire wr_l = s2_r[2];
    wire cyc_l = s2_r[3];
    wire local_bus_clock_rise = s2_r[4] & ~s3_r[4];
    wire wnr = s2_r[5];
    wire dcs_l = s2_r[6];
    wire vlb_l = s2_r[7];
    wire address_enable = s2_r[8];
    wire [3:0] be = ~s2_r[27:24];
    wire [31:0] din = s2_r[59:28];
    wire strobe_lead = (~rd_l & s3_r[1]) | (~wr_l & s3_r[2]);

    reg [14:0] lat_r;
    reg [7:0] bank_r;
    reg [AW-1:0] ptr_r;
    reg [1:0] st_r;
    reg sync_r, wr_r, dp_r;
    reg [31:0] mem [0:(1<<AW)-1];
    // host write buffer, two entries
    reg [AW-1:0] wq_a [0:1];
    reg [3:0] wq_b [0:1];
    reg [31:0] wq_d [0:1];
    reg wq_w_r, wq_r_r;
    reg [1:0] wq_n_r;
    reg [31:0] rdw_r;
    reg rdv_r;
    // DMA state
    reg [2:0] div_r;
    reg [AW-2:0] rxc_r, txc_r;
    reg [15:0] rxlo_r;
    reg [15:0] rxhi_r;
    reg rxh_r, rxf_r;
    reg [31:0] txw_r;
    reg txv_r, txhi_r;
    reg turn_r, dturn_r;

    wire hit = ~address_enable && lat_r[14:3] == BASE;
    wire [1:0] widx = lat_r[2:1];
    wire a1 = lat_r[0];
    wire dp_sel = ~dcs_l;
    wire async_go = strobe_lead && (hit || dp_sel);
    wire sync_go = ~vlb_l && local_bus_clock_rise && ~cyc_l && hit;
    wire go = st_r == `HBP_ST_IDLE && (async_go || sync_go);
    wire go_wr = async_go ? ~wr_l : wnr;
    wire go_dp = dp_sel || (bank_r[2:0] == `HBP_BANK_DP && widx == `HBP_W_DATA);
    wire cur_wr = go ? go_wr : wr_r;
    wire cur_dp = go ? go_dp : dp_r;
    // only a select-driven access skips lane and swap handling, a banked one does not
    wire byp = go ? dp_sel : (dp_r && dp_sel);
    wire [3:0] cur_be = byp ? 4'hF : be;
    wire can = ~cur_dp || (cur_wr ? wq_n_r != 2'h2 : rdv_r);
    wire act = (go || st_r == `HBP_ST_WAIT) && can;
    wire async_end = rd_l & wr_l;
    wire sync_end = cyc_l;
    wire [31:0] wdat = byp ? din : swap_h(din, a1);

    reg [31:0] rmux;
    always @* begin
        rmux = 32'h0;
        if (cur_dp)
            rmux = rdw_r;
        else if (widx == `HBP_W_BANK)
            rmux = {bank_r, 24'h0};
        else if (widx == `HBP_W_PTR && bank_r[2:0] == `HBP_BANK_DP)
            rmux = {{(32-AW){1'b0}}, ptr_r};
        else if (widx == `HBP_W_MSI && bank_r[2:0] == `HBP_BANK_MSI)
            rmux = `HBP_MEM_BYTES / `HBP_PAGE_BYTES;
    end

    wire dma_tick = div_r == `HBP_DMA_LAST;
    wire hreq = wq_n_r != 2'h0 || ~rdv_r;
    wire dreq = rxf_r || ~txv_r;
    wire pick_h = hreq && (~dreq || ~turn_r);
    wire pick_rx = rxf_r && (txv_r || ~dturn_r);
    wire rx_take = i_rx_valid && o_rx_ready;
    wire tx_load = txv_r && (~o_tx_valid || i_tx_ready);
    wire rxf_nxt = (rxf_r && !(dma_tick && !pick_h && pick_rx)) || (rx_take && rxh_r);
    integer k;

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            s1_r <= 60'h0;
            s2_r <= 60'h0;
            s3_r <= 60'h0;
            lat_r <= 15'h0;
            bank_r <= `HBP_BANK_RST;
            ptr_r <= {AW{1'b0}};
            st_r <= `HBP_ST_IDLE;
            sync_r <= 1'b0;
            wr_r <= 1'b0;
            dp_r <= 1'b0;
            wq_w_r <= 1'b0;
            wq_r_r <= 1'b0;
            wq_n_r <= 2'h0;
            rdw_r <= 32'h0;
            rdv_r <= 1'b0;
            div_r <= 3'h0;
            rxc_r <= {(AW-1){1'b0}};
            txc_r <= {(AW-1){1'b0}};
            rxlo_r <= 16'h0;
            rxh_r <= 1'b0;
            rxf_r <= 1'b0;
            txw_r <= 32'h0;
            txv_r <= 1'b0;
            txhi_r <= 1'b0;
            turn_r <= 1'b0;
            dturn_r <= 1'b0;
            // cleared so the transmit path never streams unknown words
            for (k = 0; k < (1 << AW); k = k + 1)
                mem[k] <= 32'h0;
            o_data <= 32'h0;
            o_data_oe <= 1'b0;
            o_async_cycle_ready <= 1'b1;
            o_sync_cycle_ready_low <= 1'b1;
            o_rx_ready <= 1'b0;
            o_tx_word <= 16'h0;
            o_tx_valid <= 1'b0;
        end else if (i_ce) begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (!ads_l && rd_l && wr_l)
                lat_r <= {s2_r[20:9], s2_r[22:21], s2_r[23]};
            // access sequencer
            case (st_r)
                `HBP_ST_IDLE: begin
                    if (go) begin
                        sync_r <= sync_go;
                        wr_r <= go_wr;
                        dp_r <= go_dp;
                        st_r <= can ? `HBP_ST_DONE : `HBP_ST_WAIT;
                        if (!can && !sync_go)
                            o_async_cycle_ready <= 1'b0;
                    end
                end
                `HBP_ST_WAIT: begin
                    if (can) begin
                        st_r <= `HBP_ST_DONE;
                        o_async_cycle_ready <= 1'b1;
                    end
                end
                `HBP_ST_DONE: begin
                    if (sync_r && local_bus_clock_rise)
                        o_sync_cycle_ready_low <= 1'b1;
                    if (sync_r ? sync_end : async_end) begin
                        st_r <= `HBP_ST_IDLE;
                        o_data_oe <= 1'b0;
                        o_sync_cycle_ready_low <= 1'b1;
                    end
                end
                default: st_r <= `HBP_ST_IDLE;
            endcase
            // perform the access once it can be satisfied
            if (act) begin
                o_sync_cycle_ready_low <= ~(go ? sync_go : sync_r);
                if (cur_wr) begin
                    if (cur_dp) begin
                        wq_a[wq_w_r] <= ptr_r;
                        wq_b[wq_w_r] <= cur_be;
                        wq_d[wq_w_r] <= wdat;
                        wq_w_r <= ~wq_w_r;
                    end else if (widx == `HBP_W_BANK && be[3]) begin
                        bank_r <= wdat[31:24];
                    end else if (widx == `HBP_W_PTR && bank_r[2:0] == `HBP_BANK_DP) begin
                        ptr_r <= wdat[AW-1:0];
                    end
                end else begin
                    o_data <= byp ? rmux : swap_h(rmux, a1);
                    o_data_oe <= 1'b1;
                end
                if (cur_dp && cur_be[3])
                    ptr_r <= ptr_r + 1'b1;
            end
            // packet RAM arbitration at the DMA rate
            div_r <= dma_tick ? 3'h0 : div_r + 3'h1;
            if (dma_tick && (hreq || dreq)) begin
                turn_r <= pick_h;
                if (pick_h) begin
                    if (wq_n_r != 2'h0) begin
                        for (k = 0; k < 4; k = k + 1)
                            if (wq_b[wq_r_r][k])
                                mem[wq_a[wq_r_r]][8*k +: 8] <= wq_d[wq_r_r][8*k +: 8];
                        wq_r_r <= ~wq_r_r;
                    end else begin
                        rdw_r <= mem[ptr_r];
                        rdv_r <= 1'b1;
                    end
                end else if (pick_rx) begin
                    dturn_r <= 1'b1;
                    mem[`HBP_RX_BASE + {1'b0, rxc_r}] <= {rxhi_r, rxlo_r};
                    rxc_r <= rxc_r + 1'b1;
                end else begin
                    dturn_r <= 1'b0;
                    txw_r <= mem[{1'b0, txc_r}];
                    txv_r <= 1'b1;
                    txc_r <= txc_r + 1'b1;
                end
            end
            wq_n_r <= wq_n_r + {1'b0, act && cur_wr && cur_dp}
                - {1'b0, dma_tick && pick_h && wq_n_r != 2'h0};
            // prefetch goes stale on any pointer or buffer change
            if (act && cur_dp)
                rdv_r <= 1'b0;
            if (act && cur_wr && !cur_dp && widx == `HBP_W_PTR)
                rdv_r <= 1'b0;
            // receive packing
            if (rx_take) begin
                rxh_r <= ~rxh_r;
                if (!rxh_r)
                    rxlo_r <= i_rx_word;
                else
                    rxhi_r <= i_rx_word;
            end
            rxf_r <= rxf_nxt;
            o_rx_ready <= ~rxf_nxt;
            // transmit unpacking, low half first
            if (tx_load) begin
                o_tx_word <= txhi_r ? txw_r[31:16] : txw_r[15:0];
                o_tx_valid <= 1'b1;
                txhi_r <= ~txhi_r;
                if (txhi_r)
                    txv_r <= 1'b0;
            end else if (i_tx_ready) begin
                o_tx_valid <= 1'b0;
            end
        end
    end
endmodule // hbp_top
`default_nettype wire

/* File: hbp_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module hbp_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // host side
    input wire logic i_read_strobe_low,
    input wire logic i_write_strobe_low,
    input wire logic i_cycle_frame_low,
    input wire logic i_data_path_select_low,
    input wire logic i_address_enable,
    input wire logic o_data_oe,
    input wire logic o_async_cycle_ready,
    input wire logic o_sync_cycle_ready_low,
    // mac side
    input wire logic [15:0] o_tx_word,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire strb = !i_read_strobe_low || !i_write_strobe_low;
    chk_miss_undriven: assert property ((i_address_enable && i_data_path_select_low)[*8]
        |-> !o_data_oe && o_async_cycle_ready) else $error("bus driven on a miss");
    chk_oe_release: assert property ((!strb && i_cycle_frame_low)[*5] |-> !o_data_oe)
        else $error("data bus held after strobes released");
    chk_oe_cause: assert property ($rose(o_data_oe) |-> strb || !i_cycle_frame_low)
        else $error("data bus driven without a cycle");
    chk_ready_lead: assert property ($fell(o_async_cycle_ready) |-> strb)
        else $error("async ready dropped without a strobe");
    chk_ready_bound: assert property (!o_async_cycle_ready |-> ##[1:64] o_async_cycle_ready)
        else $error("async ready held low too long");
    chk_sync_idle: assert property (i_cycle_frame_low[*5] |-> o_sync_cycle_ready_low)
        else $error("sync ready low outside a frame");
    chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid)
        else $error("transmit word withdrawn");
    chk_tx_stable: assert property (o_tx_valid && !i_tx_ready |=> $stable(o_tx_word))
        else $error("transmit word changed while stalled");
    cover property ($fell(o_async_cycle_ready));
    cover property (!o_sync_cycle_ready_low);
    cover property (o_tx_valid && !i_tx_ready);
endmodule // hbp_properties
`default_nettype wire

/* File: hbp_mac_model.sv */
`timescale 1ns/1ns
`default_nettype none
module hbp_mac_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // receive words toward the block
    input wire logic [15:0] i_seed,
    output logic [15:0] o_rx_word,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    // transmit sink
    output logic o_tx_ready
);
    logic [2:0] sent_r;
    logic [3:0] tmr_r = 4'h0;
    // sink stalls irregularly, as a busy mac would
    assign o_tx_ready = tmr_r[3] ^ tmr_r[0];
    always @(posedge i_clk) begin
        tmr_r <= tmr_r + 4'h1;
        if (!i_rstn) begin
            sent_r <= 3'h0;
            o_rx_valid <= 1'b0;
            o_rx_word <= 16'h0;
        end else if (o_rx_valid && i_rx_ready) begin
            sent_r <= sent_r + 3'h1;
            o_rx_valid <= 1'b0;
            // stale word would hide a late sample
            o_rx_word <= ~o_rx_word;
        end else if (!o_rx_valid && sent_r < 3'h4 && tmr_r[1]) begin
            o_rx_valid <= 1'b1;
            o_rx_word <= i_seed + {13'h0, sent_r};
        end
    end
endmodule // hbp_mac_model
`default_nettype wire

/* File: tb_hbp_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_hbp_top;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_local_bus_clock = 1'b0;
    logic i_address_strobe_low = 1'b1, i_read_strobe_low = 1'b1, i_write_strobe_low = 1'b1;
    logic i_cycle_frame_low = 1'b1, i_write_not_read = 1'b0, i_data_path_select_low = 1'b1;
    logic i_sync_bus_select_low = 1'b1, i_address_enable = 1'b0, i_word_half_select = 1'b0;
    logic [11:0] i_upper_address_lines = 12'h030;
    logic [1:0] i_addr_low = 2'h0;
    logic [3:0] i_byte_en_low = 4'h0;
    logic [31:0] i_data = 32'h0, o_data, q, lf = 32'h3B;
    logic [31:0] exp_q [4];
    logic [15:0] i_rx_word, o_tx_word, rx_base;
    logic o_data_oe, o_async_cycle_ready, o_sync_cycle_ready_low, qoe;
    logic i_rx_valid, o_rx_ready, o_tx_valid, i_tx_ready;
    int fails = 0, cmp_count = 0;
    always #2 i_clk = ~i_clk;
    // 8 MHz, inside the burst limit; nonblocking changes, some land on a sampling edge
    always begin
        #62 i_local_bus_clock <= 1'b1;
        #63 i_local_bus_clock <= 1'b0;
    end
    hbp_top DUT (.i_clk, .i_rstn, .i_ce, .i_address_strobe_low, .i_read_strobe_low,
        .i_write_strobe_low, .i_cycle_frame_low, .i_local_bus_clock, .i_write_not_read,
        .i_data_path_select_low, .i_sync_bus_select_low, .i_address_enable,
        .i_upper_address_lines, .i_addr_low, .i_word_half_select, .i_byte_en_low, .i_data,
        .o_data, .o_data_oe, .o_async_cycle_ready, .o_sync_cycle_ready_low, .i_rx_word,
        .i_rx_valid, .o_rx_ready, .o_tx_word, .o_tx_valid, .i_tx_ready);
    hbp_mac_model u_mac (.i_clk, .i_rstn, .i_seed(rx_base), .o_rx_word(i_rx_word),
        .o_rx_valid(i_rx_valid), .i_rx_ready(o_rx_ready), .o_tx_ready(i_tx_ready));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // two mac words per memory word, first one in the low half
    function automatic logic [31:0] rx_pair(input logic [15:0] b, input int k);
        return {b + 16'(2 * k + 1), b + 16'(2 * k)};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic timed_out;
        fails++;
        give_verdict();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic acc(input logic wr, dps, input logic [1:0] w, input logic [31:0] d);
        i_addr_low = w;
        i_data = d;
        i_data_path_select_low = !dps;
        i_address_strobe_low = 1'b0;
        tick(1);
        i_address_strobe_low = 1'b1;
        // latch must hold the address once the strobe has risen
        i_addr_low = ~w;
        if (wr) i_write_strobe_low = 1'b0;
        else i_read_strobe_low = 1'b0;
        tick(4);
        for (int k = 0; k < 100 && !o_async_cycle_ready; k++) tick(1);
        if (!o_async_cycle_ready) timed_out();
        q = o_data;
        qoe = o_data_oe;
        tick(1);
        i_read_strobe_low = 1'b1;
        i_write_strobe_low = 1'b1;
        i_data_path_select_low = 1'b1;
        tick(6);
    endtask
    task automatic sync_rd(input logic [1:0] w);
        // async strobes stay high for the whole frame
        @(posedge i_local_bus_clock);
        tick(1);
        i_addr_low = w;
        i_sync_bus_select_low = 1'b0;
        i_address_strobe_low = 1'b0;
        i_cycle_frame_low = 1'b0;
        for (int k = 0; k < 100 && o_sync_cycle_ready_low; k++) tick(1);
        if (o_sync_cycle_ready_low) timed_out();
        q = o_data;
        @(posedge i_local_bus_clock);
        tick(1);
        i_cycle_frame_low = 1'b1;
        i_address_strobe_low = 1'b1;
        i_sync_bus_select_low = 1'b1;
        tick(8);
    endtask
    initial begin
        lf = nxt(lf);
        rx_base = lf[15:0];
        tick(5);
        check("idle_oe", {31'h0, o_data_oe}, 32'h0);
        i_rstn = 1'b1;
        tick(3);
        // only the top byte of this doubleword may land
        acc(1'b1, 1'b0, 2'h3, {8'h02, lf[23:0]});
        acc(1'b0, 1'b0, 2'h3, 32'h0);
        check("bank", {24'h0, q[31:24]}, 32'h2);
        sync_rd(2'h3);
        check("sync_bank", {24'h0, q[31:24]}, 32'h2);
        for (int m = 0; m < 2; m++) begin
            i_address_enable = (m == 0);
            i_upper_address_lines = m ? 12'h031 : 12'h030;
            acc(1'b0, 1'b0, 2'h3, 32'h0);
            check("miss_oe", {31'h0, qoe}, 32'h0);
        end
        i_address_enable = 1'b0;
        i_upper_address_lines = 12'h030;
        acc(1'b1, 1'b0, 2'h3, 32'h0);
        for (int h = 0; h < 2; h++) begin
            i_word_half_select = h[0];
            acc(1'b0, 1'b0, 2'h2, 32'h0);
            check("mem_size", (q >> (16 * h)) & 32'hFF, 32'h4);
        end
        i_word_half_select = 1'b0;
        acc(1'b1, 1'b0, 2'h3, 32'h02000000);
        acc(1'b1, 1'b0, 2'h1, 32'h10);
        // decode is off, the select alone must carry the access
        i_address_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            lf = nxt(lf);
            exp_q[k] = lf;
            acc(1'b1, 1'b1, 2'h0, lf);
        end
        i_address_enable = 1'b0;
        acc(1'b1, 1'b0, 2'h1, 32'h10);
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, 1'b1, 2'h0, 32'h0);
            check("dp_word", q, exp_q[k]);
        end
        acc(1'b1, 1'b0, 2'h1, 32'h400);
        for (int k = 0; k < 2; k++) begin
            acc(1'b0, 1'b0, 2'h2, 32'h0);
            check("rx_pair", q, rx_pair(rx_base, k));
        end
        give_verdict();
    end
endmodule // tb_hbp_top
bind hbp_top hbp_properties u_props (.i_clk, .i_rstn, .i_read_strobe_low,
    .i_write_strobe_low, .i_cycle_frame_low, .i_data_path_select_low, .i_address_enable,
    .o_data_oe, .o_async_cycle_ready, .o_sync_cycle_ready_low, .o_tx_word, .o_tx_valid,
    .i_tx_ready);
`default_nettype wire
